/* dv/sca_rtc_block_bench.sv */
// self-checking bench of the seconds counter and alarm block
`timescale 1ns/1ps
module sca_rtc_block_bench;
  // ==========================================================================
  // signals
  localparam int OSC_SIM = 16;
  typedef struct {logic [14:0] idx; logic [15:0] rstVal;} sca_row_t;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [16:0] paddr = 17'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic osc32k = 1'b0;
  logic keyUnlocked = 1'b0;
  logic pwrSleep = 1'b0;
  logic pwrOff = 1'b0;
  logic clockIrq;
  logic wakeReq;
  logic onReq;
  logic [31:0] rdVal;
  logic errSeen;
  logic [15:0] tamp;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int wakeCnt = 0;
  int onCnt = 0;
  sca_row_t rows [9] = '{
    '{sca_pkg::IDX_EVENT_STATUS, 16'h0000}, '{sca_pkg::IDX_EVENT_MASK, 16'h000c},
    '{sca_pkg::IDX_TAMPER_CNT, sca_pkg::RST_TAMPER_CNT},
    '{sca_pkg::IDX_SECONDS_HIGH, 16'h0000}, '{sca_pkg::IDX_SECONDS_LOW, 16'h0000},
    '{sca_pkg::IDX_ALARM_HIGH, 16'h0000}, '{sca_pkg::IDX_ALARM_LOW, 16'h0000},
    '{sca_pkg::IDX_CLOCK_CONTROL, 16'h0000}, '{sca_pkg::IDX_FREQ_TRIM, 16'h0000}};

  always #50 core_clk = ~core_clk;

  sca_rtc_block #(.OSC_HZ(OSC_SIM)) dut_u (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .osc32k(osc32k),
    .keyUnlocked(keyUnlocked),
    .pwrSleep(pwrSleep),
    .pwrOff(pwrOff),
    .clockIrq(clockIrq),
    .wakeReq(wakeReq),
    .onReq(onReq)
  );

  // ==========================================================================
  // tasks
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer, held until pready is seen high at a rising edge
  task automatic xfer(input logic wr, input logic [14:0] idx, input logic [15:0] data);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {16'h0000, data};
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    errSeen = pslverr;
    rdVal = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [14:0] idx);
    xfer(1'b0, idx, 16'h0000);
  endtask : rd

  // write, then poll until the update has synchronised
  task automatic wr(input logic [14:0] idx, input logic [15:0] data);
    xfer(1'b1, idx, data);
    do rd(sca_pkg::IDX_CLOCK_CONTROL); while (rdVal[sca_pkg::BIT_BUSY] !== 1'b0);
  endtask : wr

  task automatic oscSec(input int n);
    repeat (n * OSC_SIM) begin
      @(posedge core_clk);
      osc32k <= 1'b1;
      repeat (2) @(posedge core_clk);
      osc32k <= 1'b0;
      @(posedge core_clk);
    end
    repeat (4) @(posedge core_clk);
  endtask : oscSec

  // ==========================================================================
  // monitors and timeout
  always @(posedge core_clk) begin
    if (wakeReq === 1'b1) wakeCnt++;
    if (onReq === 1'b1) onCnt++;
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      wrap_up();
    end
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].idx);
      check(rdVal, {16'h0000, rows[i].rstVal});
    end
    $display("test reset values done");
    rd(15'h4030);
    check({31'h0, errSeen}, 32'h1);
    check(rdVal, 32'h0);
    wr(sca_pkg::IDX_FREQ_TRIM, 16'h0005);
    rd(sca_pkg::IDX_FREQ_TRIM);
    check(rdVal, 32'h0);
    keyUnlocked <= 1'b1;
    wr(sca_pkg::IDX_FREQ_TRIM, 16'h03c1);
    rd(sca_pkg::IDX_FREQ_TRIM);
    check(rdVal, 32'h3c1);
    wr(sca_pkg::IDX_FREQ_TRIM, 16'h0000);
    $display("test trim and unmapped done");
    xfer(1'b1, sca_pkg::IDX_SECONDS_HIGH, 16'h0001);
    rd(sca_pkg::IDX_CLOCK_CONTROL);
    check({30'h0, rdVal[15:14]}, 32'h3);
    wr(sca_pkg::IDX_CLOCK_CONTROL, 16'h0000);
    rd(sca_pkg::IDX_TAMPER_CNT);
    tamp = rdVal[15:0];
    check({31'h0, tamp != 16'h0}, 32'h1);
    wr(sca_pkg::IDX_SECONDS_LOW, 16'hfffe);
    rd(sca_pkg::IDX_TAMPER_CNT);
    check({31'h0, rdVal[15:0] != tamp}, 32'h1);
    oscSec(3);
    rd(sca_pkg::IDX_SECONDS_HIGH);
    check(rdVal, 32'h0002);
    rd(sca_pkg::IDX_SECONDS_LOW);
    check(rdVal, 32'h0001);
    $display("test seconds done");
    wr(sca_pkg::IDX_ALARM_HIGH, 16'h0002);
    wr(sca_pkg::IDX_ALARM_LOW, 16'h0002);
    wr(sca_pkg::IDX_EVENT_MASK, 16'h0008);
    pwrSleep <= 1'b1;
    wr(sca_pkg::IDX_CLOCK_CONTROL, 16'h0400);
    oscSec(1);
    rd(sca_pkg::IDX_EVENT_STATUS);
    check(rdVal, 32'h0004);
    check({31'h0, clockIrq}, 32'h1);
    check(wakeCnt, 1);
    check(onCnt, 0);
    wr(sca_pkg::IDX_EVENT_STATUS, 16'h0004);
    rd(sca_pkg::IDX_EVENT_STATUS);
    check(rdVal, 32'h0000);
    check({31'h0, clockIrq}, 32'h0);
    pwrSleep <= 1'b0;
    pwrOff <= 1'b1;
    wr(sca_pkg::IDX_ALARM_LOW, 16'h0003);
    oscSec(1);
    check(onCnt, 1);
    check(wakeCnt, 1);
    wr(sca_pkg::IDX_EVENT_STATUS, 16'h0004);
    pwrOff <= 1'b0;
    $display("test alarm done");
    wr(sca_pkg::IDX_CLOCK_CONTROL, 16'h0010);
    oscSec(1);
    rd(sca_pkg::IDX_EVENT_STATUS);
    check(rdVal, 32'h0000);
    oscSec(1);
    rd(sca_pkg::IDX_EVENT_STATUS);
    check(rdVal, 32'h0008);
    check({31'h0, clockIrq}, 32'h0);
    wr(sca_pkg::IDX_CLOCK_CONTROL, 16'h0000);
    wr(sca_pkg::IDX_EVENT_STATUS, 16'h0008);
    oscSec(2);
    rd(sca_pkg::IDX_EVENT_STATUS);
    check(rdVal, 32'h0000);
    $display("test periodic done");
    for (int i = 0; i < 6; i++) wr(sca_pkg::IDX_SECONDS_LOW, 16'(i));
    rd(sca_pkg::IDX_TAMPER_CNT);
    tamp = rdVal[15:0];
    wr(sca_pkg::IDX_SECONDS_LOW, 16'h1234);
    rd(sca_pkg::IDX_SECONDS_LOW);
    check(rdVal, 32'h0005);
    rd(sca_pkg::IDX_TAMPER_CNT);
    check(rdVal, {16'h0000, tamp});
    $display("test update limit done");
    wr(sca_pkg::IDX_FREQ_TRIM, 16'h0040);
    oscSec(1);
    rd(sca_pkg::IDX_SECONDS_LOW);
    check(rdVal, 32'h0005);
    oscSec(1);
    rd(sca_pkg::IDX_SECONDS_LOW);
    check(rdVal, 32'h0006);
    $display("test trim rate done");
    rst_n <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(sca_pkg::IDX_CLOCK_CONTROL);
    check(rdVal, 32'h0000);
    rd(sca_pkg::IDX_SECONDS_LOW);
    check(rdVal, 32'h0000);
    rd(sca_pkg::IDX_TAMPER_CNT);
    check(rdVal, 32'h0000);
    rd(sca_pkg::IDX_EVENT_MASK);
    check(rdVal, 32'h000c);
    $display("test second reset done");
    wrap_up();
  end
endmodule : sca_rtc_block_bench

/* logic/sca_pkg.sv */
// constants and register map of the seconds counter and alarm block
package sca_pkg;

  // ==========================================================================
  // register indices (byte address is four times the index)
  localparam logic [14:0] IDX_EVENT_STATUS = 15'h4011;
  localparam logic [14:0] IDX_EVENT_MASK = 15'h4019;
  localparam logic [14:0] IDX_TAMPER_CNT = 15'h4020;
  localparam logic [14:0] IDX_SECONDS_HIGH = 15'h4021;
  localparam logic [14:0] IDX_SECONDS_LOW = 15'h4022;
  localparam logic [14:0] IDX_ALARM_HIGH = 15'h4023;
  localparam logic [14:0] IDX_ALARM_LOW = 15'h4024;
  localparam logic [14:0] IDX_CLOCK_CONTROL = 15'h4025;
  localparam logic [14:0] IDX_FREQ_TRIM = 15'h4026;

  // ==========================================================================
  // field positions
  localparam int BIT_PERIODIC_FLAG = 3;
  localparam int BIT_ALARM_FLAG = 2;
  localparam int BIT_VALID = 15;
  localparam int BIT_BUSY = 14;
  localparam int BIT_ALARM_ENABLE = 10;
  localparam int POS_INTERVAL_LSB = 4;
  localparam int TRIM_WIDTH = 10;
  localparam int TRIM_FRAC_BITS = 6;

  // ==========================================================================
  // reset values
  localparam logic [15:0] RST_TAMPER_CNT = 16'h0000;
  localparam logic [31:0] RST_SECONDS = 32'h0000_0000;
  localparam logic [31:0] RST_ALARM = 32'h0000_0000;
  localparam logic [9:0] RST_TRIM = 10'h000;
  localparam logic [2:0] RST_INTERVAL = 3'h0;
  localparam logic RST_ALARM_ENABLE = 1'b0;
  localparam logic RST_EVENT_MASK = 1'b1;
  localparam logic [15:0] PRNG_SEED = 16'hace1;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int SYNC_TIME_NS = 400;
  localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_NOMINAL_HZ = 32768;
  localparam int MAX_UPDATES = 8;
  localparam int UPDATE_WINDOW_S = 3600;

endpackage : sca_pkg

/* logic/sca_prng.sv */
// free-running 16-bit pseudo-random generator
`timescale 1ns/1ps
module sca_prng (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic [15:0] randVal
);

  logic [15:0] lfsr_reg;

  // galois lfsr, taps 16,14,13,11; never reaches zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_reg <= sca_pkg::PRNG_SEED;
    end else begin
      lfsr_reg <= {1'b0, lfsr_reg[15:1]} ^ (lfsr_reg[0] ? 16'hb400 : 16'h0000);
    end
  end

  assign randVal = lfsr_reg;

endmodule : sca_prng

/* logic/sca_rtc_block.sv */
// seconds counter, alarm, periodic timeout and tamper counter behind apb
//
// Function
// RQ1: tamper counter resets to zero, loads a random value on seconds writes
// RQ2: seconds counter advances by exactly one each elapsed second
// RQ3: seconds upper half at first address, lower half at next
// RQ4: both seconds words reset to zero
// RQ5: alarm value held as upper and lower words, both reset zero
// RQ6: read-only valid flag at control bit 15, set by seconds write
// RQ7: busy flag at control bit 14 while an update synchronises
// RQ8: alarm flag set when alarm fires; enable at control bit 10
// RQ9: trim is ten-bit signed fixed point, four integer six fraction bits
// RQ10: trim writes ignored while the user key is locked
// RQ11: periodic flag set each time the periodic timeout elapses
// RQ12: interval field bits 6:4; zero off, else 2 to 128 seconds
// RQ13: event flags set on rising source edge, cleared by writing one
// RQ14: mask bits 3 and 2 suppress events, reset to masked
// RQ15: any unmasked event flag raises the clock interrupt
// RQ16: alarm fires when enabled and seconds equal alarm value
// RQ17: alarm in sleep requests wake, alarm in off requests on
// RQ18: at most eight seconds updates per hour, further writes ignored
// RQ19: seconds tick derived from oscillator, corrected by trim
// RQ20: trim adjusts cycles per second, fraction accumulated across seconds
// RQ21: random value sampled from free-running generator at accepted write
`timescale 1ns/1ps
module sca_rtc_block #(
  parameter int OSC_HZ = sca_pkg::OSC_NOMINAL_HZ
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [16:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc32k,
  input wire logic keyUnlocked,
  input wire logic pwrSleep,
  input wire logic pwrOff,
  output logic clockIrq,
  output logic wakeReq,
  output logic onReq
);

  // ==========================================================================
  // address decoding
  function automatic logic isMapped(input logic [14:0] idx);
    isMapped = (idx == sca_pkg::IDX_EVENT_STATUS) || (idx == sca_pkg::IDX_EVENT_MASK) ||
               ((idx >= sca_pkg::IDX_TAMPER_CNT) && (idx <= sca_pkg::IDX_FREQ_TRIM));
  endfunction : isMapped

  function automatic logic isClockReg(input logic [14:0] idx);
    isClockReg = (idx >= sca_pkg::IDX_SECONDS_HIGH) && (idx <= sca_pkg::IDX_FREQ_TRIM);
  endfunction : isClockReg

  logic [14:0] regIdx;
  logic [31:0] prdata_reg, readMux;
  logic pready_reg, pslverr_reg, wrDone, clkWr, secsWrReq, secsWrAcc, rateOk;

  logic [15:0] tamperCnt_reg, randVal;
  logic [31:0] seconds_reg, alarm_reg, uptime_reg, oldestStamp;
  logic [2:0] busyCnt_reg, interval_reg, stampHead_reg;
  logic [9:0] trim_reg;
  logic [3:0] stampFill_reg;
  logic [7:0] perCnt_reg;
  logic [23:0] fracAcc_reg, fracSum, secTarget;
  logic valid_reg, busy_reg, alarmEn_reg, perFlag_reg, almFlag_reg, perMask_reg, almMask_reg;
  logic clockIrq_reg, wakeReq_reg, onReq_reg, oscPrev_reg, oscRise, secTick_reg, perPulse_reg;
  logic alarmHit, alarmHitPrev_reg, alarmRise;

  assign regIdx = paddr[16:2];
  assign wrDone = psel && penable && pready_reg && pwrite && isMapped(regIdx);
  assign clkWr = wrDone && isClockReg(regIdx) && !busy_reg; // [RQ7]
  assign secsWrReq = clkWr &&
    ((regIdx == sca_pkg::IDX_SECONDS_HIGH) || (regIdx == sca_pkg::IDX_SECONDS_LOW));
  assign secsWrAcc = secsWrReq && rateOk; // [RQ18]

  // ==========================================================================
  // apb slave: one wait state, answer from flops
  always_comb begin
    readMux = 32'h0000_0000;
    if (regIdx == sca_pkg::IDX_EVENT_STATUS) begin
      readMux[sca_pkg::BIT_PERIODIC_FLAG] = perFlag_reg;
      readMux[sca_pkg::BIT_ALARM_FLAG] = almFlag_reg;
    end else if (regIdx == sca_pkg::IDX_EVENT_MASK) begin
      readMux[sca_pkg::BIT_PERIODIC_FLAG] = perMask_reg;
      readMux[sca_pkg::BIT_ALARM_FLAG] = almMask_reg;
    end else if (regIdx == sca_pkg::IDX_TAMPER_CNT) begin
      readMux[15:0] = tamperCnt_reg;
    end else if (regIdx == sca_pkg::IDX_SECONDS_HIGH) begin
      readMux[15:0] = seconds_reg[31:16]; // [RQ3]
    end else if (regIdx == sca_pkg::IDX_SECONDS_LOW) begin
      readMux[15:0] = seconds_reg[15:0]; // [RQ3]
    end else if (regIdx == sca_pkg::IDX_ALARM_HIGH) begin
      readMux[15:0] = alarm_reg[31:16]; // [RQ5]
    end else if (regIdx == sca_pkg::IDX_ALARM_LOW) begin
      readMux[15:0] = alarm_reg[15:0]; // [RQ5]
    end else if (regIdx == sca_pkg::IDX_CLOCK_CONTROL) begin
      readMux[sca_pkg::BIT_VALID] = valid_reg; // [RQ6]
      readMux[sca_pkg::BIT_BUSY] = busy_reg; // [RQ7]
      readMux[sca_pkg::BIT_ALARM_ENABLE] = alarmEn_reg;
      readMux[sca_pkg::POS_INTERVAL_LSB +: 3] = interval_reg;
    end else if (regIdx == sca_pkg::IDX_FREQ_TRIM) begin
      readMux[sca_pkg::TRIM_WIDTH-1:0] = trim_reg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      if (psel && penable && !pready_reg) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : readMux;
        pslverr_reg <= !isMapped(regIdx);
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // control, alarm and trim registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_reg <= sca_pkg::RST_ALARM; // [RQ5]
      alarmEn_reg <= sca_pkg::RST_ALARM_ENABLE; // [RQ8]
      interval_reg <= sca_pkg::RST_INTERVAL; // [RQ12]
      trim_reg <= sca_pkg::RST_TRIM;
    end else if (clkWr) begin
      if (regIdx == sca_pkg::IDX_ALARM_HIGH) begin
        alarm_reg[31:16] <= pwdata[15:0];
      end else if (regIdx == sca_pkg::IDX_ALARM_LOW) begin
        alarm_reg[15:0] <= pwdata[15:0];
      end else if (regIdx == sca_pkg::IDX_CLOCK_CONTROL) begin
        alarmEn_reg <= pwdata[sca_pkg::BIT_ALARM_ENABLE];
        interval_reg <= pwdata[sca_pkg::POS_INTERVAL_LSB +: 3];
      end else if (regIdx == sca_pkg::IDX_FREQ_TRIM && keyUnlocked) begin
        trim_reg <= pwdata[sca_pkg::TRIM_WIDTH-1:0]; // [RQ10]
      end
    end
  end

  // busy for a fixed sync time after any clock register write
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busyCnt_reg <= 3'h0;
      busy_reg <= 1'b0;
    end else if (clkWr) begin
      busyCnt_reg <= 3'(sca_pkg::SYNC_CYCLES); // [RQ7]
      busy_reg <= 1'b1;
    end else if (busyCnt_reg != 3'h0) begin
      busyCnt_reg <= busyCnt_reg - 3'h1;
      busy_reg <= busyCnt_reg != 3'h1;
    end
  end

  // ==========================================================================
  // second tick from oscillator with fractional trim
  assign oscRise = osc32k && !oscPrev_reg;
  assign fracSum = fracAcc_reg + 24'h000040;
  // cycles per second times 64 plus signed trim in 1/64 hz
  assign secTarget = (24'(OSC_HZ) << sca_pkg::TRIM_FRAC_BITS) +
                     {{14{trim_reg[9]}}, trim_reg}; // [RQ9] [RQ20]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscPrev_reg <= 1'b0;
      fracAcc_reg <= 24'h000000;
      secTick_reg <= 1'b0;
    end else begin
      oscPrev_reg <= osc32k;
      secTick_reg <= 1'b0;
      if (oscRise) begin
        if (fracSum >= secTarget) begin
          fracAcc_reg <= fracSum - secTarget; // [RQ20]
          secTick_reg <= 1'b1; // [RQ19]
        end else begin
          fracAcc_reg <= fracSum;
        end
      end
    end
  end

  // ==========================================================================
  // seconds counter, valid flag, tamper counter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      seconds_reg <= sca_pkg::RST_SECONDS; // [RQ4]
      uptime_reg <= 32'h0000_0000;
    end else begin
      if (secsWrAcc && regIdx == sca_pkg::IDX_SECONDS_HIGH) begin
        seconds_reg[31:16] <= pwdata[15:0]; // [RQ3]
      end else if (secsWrAcc) begin
        seconds_reg[15:0] <= pwdata[15:0]; // [RQ3]
      end else if (secTick_reg) begin
        seconds_reg <= seconds_reg + 32'h0000_0001; // [RQ2]
      end
      if (secTick_reg) begin
        uptime_reg <= uptime_reg + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_reg <= 1'b0;
      tamperCnt_reg <= sca_pkg::RST_TAMPER_CNT; // [RQ1]
    end else if (secsWrAcc) begin
      valid_reg <= 1'b1; // [RQ6]
      tamperCnt_reg <= randVal; // [RQ1] [RQ21]
    end
  end

  sca_prng u_prng (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .randVal(randVal)
  );

  // ==========================================================================
  // update rate limit over a sliding hour of uptime
  assign rateOk = (stampFill_reg < 4'(sca_pkg::MAX_UPDATES)) ||
                  ((uptime_reg - oldestStamp) >= 32'(sca_pkg::UPDATE_WINDOW_S)); // [RQ18]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stampHead_reg <= 3'h0;
      stampFill_reg <= 4'h0;
    end else if (secsWrAcc) begin
      stampHead_reg <= stampHead_reg + 3'h1;
      if (stampFill_reg < 4'(sca_pkg::MAX_UPDATES)) begin
        stampFill_reg <= stampFill_reg + 4'h1;
      end
    end
  end

  sca_stamp_mem u_stamps (
    .core_clk(core_clk),
    .wrEn(secsWrAcc),
    .wrAddr(stampHead_reg),
    .wrData(uptime_reg),
    .rdAddr(stampHead_reg),
    .rdData(oldestStamp)
  );

  // ==========================================================================
  // periodic timeout and alarm compare
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      perCnt_reg <= 8'h00;
      perPulse_reg <= 1'b0;
    end else begin
      perPulse_reg <= 1'b0;
      if (interval_reg == 3'h0 || clkWr && regIdx == sca_pkg::IDX_CLOCK_CONTROL) begin
        perCnt_reg <= 8'h00; // [RQ12]
      end else if (secTick_reg) begin
        if (perCnt_reg + 8'h01 == 8'h01 << interval_reg) begin
          perCnt_reg <= 8'h00;
          perPulse_reg <= 1'b1; // [RQ11]
        end else begin
          perCnt_reg <= perCnt_reg + 8'h01;
        end
      end
    end
  end

  assign alarmHit = alarmEn_reg && (seconds_reg == alarm_reg); // [RQ16]
  assign alarmRise = alarmHit && !alarmHitPrev_reg; // [RQ13]

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarmHitPrev_reg <= 1'b0;
      wakeReq_reg <= 1'b0;
      onReq_reg <= 1'b0;
    end else begin
      alarmHitPrev_reg <= alarmHit;
      wakeReq_reg <= alarmRise && pwrSleep; // [RQ17]
      onReq_reg <= alarmRise && pwrOff; // [RQ17]
    end
  end

  // ==========================================================================
  // event flags, masks, interrupt
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      perFlag_reg <= 1'b0;
      almFlag_reg <= 1'b0;
    end else begin
      // set wins over a same-cycle clear
      perFlag_reg <= perPulse_reg || perFlag_reg && !(wrDone &&
        regIdx == sca_pkg::IDX_EVENT_STATUS && pwdata[sca_pkg::BIT_PERIODIC_FLAG]); // [RQ13]
      almFlag_reg <= alarmRise || almFlag_reg && !(wrDone &&
        regIdx == sca_pkg::IDX_EVENT_STATUS && pwdata[sca_pkg::BIT_ALARM_FLAG]); // [RQ8]
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      perMask_reg <= sca_pkg::RST_EVENT_MASK; // [RQ14]
      almMask_reg <= sca_pkg::RST_EVENT_MASK; // [RQ14]
    end else if (wrDone && regIdx == sca_pkg::IDX_EVENT_MASK) begin
      perMask_reg <= pwdata[sca_pkg::BIT_PERIODIC_FLAG];
      almMask_reg <= pwdata[sca_pkg::BIT_ALARM_FLAG];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clockIrq_reg <= 1'b0;
    end else begin
      clockIrq_reg <= (perFlag_reg && !perMask_reg) || (almFlag_reg && !almMask_reg); // [RQ15]
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign clockIrq = clockIrq_reg;
  assign wakeReq = wakeReq_reg;
  assign onReq = onReq_reg;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence busyHold;
    busy_reg [*4] ##1 !busy_reg;
  endsequence

  sequence flagThenIrq;
    ##1 clockIrq;
  endsequence

  AST_TAMPER_LOAD: assert property (secsWrAcc |=> tamperCnt_reg == $past(randVal)) // [RQ1]
    else $error("tamper counter did not take the random value");
  AST_SECONDS_STEP: assert property (secTick_reg && !secsWrAcc |=>
    seconds_reg == $past(seconds_reg) + 32'h0000_0001) // [RQ2]
    else $error("seconds counter did not step by one");
  AST_VALID_SET: assert property (secsWrAcc |=> valid_reg [*3]) // [RQ6]
    else $error("valid flag not held after seconds write");
  AST_BUSY_WINDOW: assert property (clkWr |=> busyHold) // [RQ7]
    else $error("busy window length wrong");
  AST_ALARM_FLAG: assert property (alarmEn_reg && seconds_reg == alarm_reg &&
    !alarmHitPrev_reg |=> almFlag_reg) // [RQ8]
    else $error("alarm flag not set on match");
  AST_W1C_CLEAR: assert property (wrDone && regIdx == sca_pkg::IDX_EVENT_STATUS &&
    pwdata[sca_pkg::BIT_ALARM_FLAG] && !alarmRise |=> !almFlag_reg) // [RQ13]
    else $error("alarm flag not cleared by write of one");
  AST_IRQ_UNMASKED: assert property (perFlag_reg && !perMask_reg |-> flagThenIrq) // [RQ15]
    else $error("unmasked periodic flag did not raise interrupt");
  AST_TRIM_LOCK: assert property (clkWr && regIdx == sca_pkg::IDX_FREQ_TRIM &&
    !keyUnlocked |=> $stable(trim_reg)) // [RQ10]
    else $error("trim changed while key locked");
  AST_RATE_LIMIT: assert property (secsWrReq && !rateOk |=>
    $stable(tamperCnt_reg) && $stable(stampFill_reg)) // [RQ18]
    else $error("seconds write accepted beyond rate limit");
  AST_PERIOD_OFF: assert property (interval_reg == 3'h0 |=> !perPulse_reg) // [RQ12]
    else $error("periodic event while disabled");
  AST_WAKE_REQ: assert property (alarmRise && pwrSleep |=> wakeReq ##1 !wakeReq) // [RQ17]
    else $error("wake request not a single pulse");

endmodule : sca_rtc_block

/* logic/sca_stamp_mem.sv */
// eight-entry store of update time stamps, registered read
`timescale 1ns/1ps
module sca_stamp_mem (
  input wire logic core_clk,
  input wire logic wrEn,
  input wire logic [2:0] wrAddr,
  input wire logic [31:0] wrData,
  input wire logic [2:0] rdAddr,
  output logic [31:0] rdData
);

  logic [31:0] mem [0:7];

  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end

endmodule : sca_stamp_mem
